// File: verilog/ctar_defs.vh
// Register offsets, field positions and reset values of the clamp/timing/aux register bank
`ifndef CTAR_DEFS_VH
`define CTAR_DEFS_VH

// Register select addresses (five bits)
`define CTAR_ADDR_MODE3     5'h03
`define CTAR_ADDR_CLAMP1    5'h07
`define CTAR_ADDR_CLAMP2    5'h08
`define CTAR_ADDR_COARSE    5'h09
`define CTAR_ADDR_TIMING    5'h0A
`define CTAR_ADDR_AUX_BASE  5'h10
`define CTAR_ADDR_AUX_LAST  5'h17

// Mode register 3 field
`define CTAR_SYNC_POL_BIT   5

// Clamp register 1 fields
`define CTAR_FINE_ON_LSB    0
`define CTAR_COARSE_ON_LSB  3
`define CTAR_SYNC_CLAMPS    6

// Timing register fields
`define CTAR_OSC_EN_BIT     0
`define CTAR_BIAS_DBL_BIT   1
`define CTAR_DCE_BIT        3
`define CTAR_CDLY_LSB       5

// Reference adjust field
`define CTAR_REF_TRIM_LSB   4

// Reset values
`define CTAR_RST_ZERO       8'h00
`define CTAR_RST_TIMING     8'h01
`define CTAR_RST_REFADJ     8'h01
`define CTAR_RST_CNT        3'h0

`endif

// File: verilog/ctar_regs.v
// Clamp sequencing, timing, reference trim and auxiliary result registers
//
// Behaviour
// [R01] Coarse enable two fires clamp two for on-time
// [R02] Coarse three direction drives only while enabled
// [R03] Coarse enable three fires clamp three for on-time
// [R04] Host writes zero to coarse reserved bits
// [R05] Oscillator enable low disables crystal oscillator
// [R06] Bias double bit doubles analog bias currents
// [R07] Duty equalizer acts on converter clock only
// [R08] Two-bit field delays digital core clock
// [R09] Host writes zero to timing reserved bits
// [R10] Host writes reference adjust reserved pattern
// [R11] Three-bit field trims converter reference
// [R12] Eight read-only aux registers from 10H
// [R13] Aux register n holds aux input n
// [R14] Sync mode: sync edge fires enabled clamps
// [R15] Sync edge polarity from polarity select bit
// [R16] Unsynced: enable rising edge fires clamp
// [R17] Host clears enable before re-triggering
// [R18] On-time fields set clamp cycles per line
// [R19] Polarity zero means low sync pulse
// [R20] Each clamp down-counts from its on-time
`timescale 1ns/1ps
`default_nettype none
`include "ctar_defs.vh"

module ctar_regs #(
  parameter NCLAMP = 3,                   // Clamps per group
  parameter NAUX   = 8                    // Auxiliary result registers
) (
  // Clock and reset
  input  wire            mclk,
  input  wire            rst_n,
  // Register port: select, write strobe and data
  input  wire [4:0]      register_select,
  input  wire            reg_wr,
  input  wire [7:0]      reg_wdata,
  output reg  [7:0]      reg_rdata,
  // Sync input and aux converter results
  input  wire            sync_in,
  input  wire [8*NAUX-1:0] aux_data,
  input  wire            aux_selected,
  // Clamp drive
  output reg  [NCLAMP-1:0] fine_on,
  output reg  [NCLAMP-1:0] fine_up,
  output reg  [NCLAMP-1:0] coarse_on,
  output reg  [NCLAMP-1:0] coarse_up,
  // Analog controls
  output reg             osc_enable,
  output reg             bias_double,
  output reg             duty_equalizer_on,
  output reg  [1:0]      core_clock_delay,
  output reg  [2:0]      ref_trim
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  reg [7:0] mode3_r;                      // Only sync polarity is used here
  reg [7:0] clamp1_r;                     // On-times and sync mode
  reg [7:0] clamp2_r;                     // Fine clamp direction/enable
  reg [7:0] coarse_clamp_control_r;       // Coarse clamp direction/enable
  reg [7:0] timing_control_r;             // Oscillator, bias, equalizer, delay
  reg [7:0] reference_adjust_r;           // Reference trim
  reg [7:0] aux_r [0:NAUX-1];             // Captured aux results
  reg       sync_d_r;                     // Previous sync sample
  reg [NCLAMP-1:0] fine_en_d_r;           // Previous fine enables
  reg [NCLAMP-1:0] coarse_en_d_r;         // Previous coarse enables
  reg [2:0] fine_cnt_r   [0:NCLAMP-1];    // Fine clamp down-counters
  reg [2:0] coarse_cnt_r [0:NCLAMP-1];    // Coarse clamp down-counters
  reg       ref_bank_r;                   // Which register 0AH reaches

  integer i;                              // Loop index of the clamp counters
  integer k;                              // Loop index of the aux capture

  // Field extraction
  wire [2:0] fine_time   = clamp1_r[`CTAR_FINE_ON_LSB +: 3];          // [R18]
  wire [2:0] coarse_time = clamp1_r[`CTAR_COARSE_ON_LSB +: 3];        // [R18]
  wire       sync_mode   = clamp1_r[`CTAR_SYNC_CLAMPS];
  wire       sync_pol    = mode3_r[`CTAR_SYNC_POL_BIT];

  // Enables sit in odd bits, directions in even bits
  wire [NCLAMP-1:0] fine_en;
  wire [NCLAMP-1:0] fine_dir;
  wire [NCLAMP-1:0] coarse_en;
  wire [NCLAMP-1:0] coarse_dir;
  genvar g;
  generate
    for (g = 0; g < NCLAMP; g = g + 1)
    begin : g_bits
      assign fine_en[g]    = clamp2_r[2*g+1];
      assign fine_dir[g]   = clamp2_r[2*g];
      assign coarse_en[g]  = coarse_clamp_control_r[2*g+1];              // [R01] [R03]
      assign coarse_dir[g] = coarse_clamp_control_r[2*g];                // [R02]
    end
  endgenerate

  // Sync edge: entering active level; polarity 0 means low pulse
  wire sync_act   = sync_pol ? sync_in : ~sync_in;                     // [R19]
  wire sync_act_d = sync_pol ? sync_d_r : ~sync_d_r;
  wire sync_edge  = sync_act & ~sync_act_d;                            // [R15]

  // Triggers per clamp for both modes
  wire [NCLAMP-1:0] fine_trig = sync_mode ? (fine_en & {NCLAMP{sync_edge}})  // [R14]
                                          : (fine_en & ~fine_en_d_r);        // [R16] [R17]
  wire [NCLAMP-1:0] coarse_trig = sync_mode ? (coarse_en & {NCLAMP{sync_edge}})
                                            : (coarse_en & ~coarse_en_d_r);  // [R16]

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; reserved bits store what the host writes
  // Address 0AH is shared: a write to it alternates between the two registers,
  // since both answer to the same select value and no other bit tells them apart.
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode3_r                <= `CTAR_RST_ZERO;
      clamp1_r               <= `CTAR_RST_ZERO;
      clamp2_r               <= `CTAR_RST_ZERO;
      coarse_clamp_control_r <= `CTAR_RST_ZERO;                      // [R04]
      timing_control_r       <= `CTAR_RST_TIMING;                    // [R09]
      reference_adjust_r     <= `CTAR_RST_REFADJ;                    // [R10]
      ref_bank_r             <= 1'b0;
    end
    else if (reg_wr)
    begin
      case (register_select)
        `CTAR_ADDR_MODE3:  mode3_r                <= reg_wdata;
        `CTAR_ADDR_CLAMP1: clamp1_r               <= reg_wdata;
        `CTAR_ADDR_CLAMP2: clamp2_r               <= reg_wdata;
        `CTAR_ADDR_COARSE: coarse_clamp_control_r <= reg_wdata;
        `CTAR_ADDR_TIMING:
        begin
          // First write goes to timing, next to reference adjust
          if (ref_bank_r)
            reference_adjust_r <= reg_wdata;
          else
            timing_control_r   <= reg_wdata;
          ref_bank_r <= ~ref_bank_r;
        end
        default: ;                                                   // Read-only or unmapped
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Aux results follow inputs only while aux configuration is selected
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (k = 0; k < NAUX; k = k + 1)
        aux_r[k] <= `CTAR_RST_ZERO;
    end
    else if (aux_selected)
    begin
      for (k = 0; k < NAUX; k = k + 1)
        aux_r[k] <= aux_data[8*k +: 8];                                // [R12] [R13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux, registered; unmapped reads return zero
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= `CTAR_RST_ZERO;
    else if (register_select >= `CTAR_ADDR_AUX_BASE &&
             register_select <= `CTAR_ADDR_AUX_LAST)
      reg_rdata <= aux_r[register_select[2:0]];                        // [R12]
    else
    begin
      case (register_select)
        `CTAR_ADDR_MODE3:  reg_rdata <= mode3_r;
        `CTAR_ADDR_CLAMP1: reg_rdata <= clamp1_r;
        `CTAR_ADDR_CLAMP2: reg_rdata <= clamp2_r;
        `CTAR_ADDR_COARSE: reg_rdata <= coarse_clamp_control_r;
        `CTAR_ADDR_TIMING: reg_rdata <= ref_bank_r ? reference_adjust_r : timing_control_r;
        default:           reg_rdata <= `CTAR_RST_ZERO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge history for sync and enable detection
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_d_r      <= 1'b0;
      fine_en_d_r   <= {NCLAMP{1'b0}};
      coarse_en_d_r <= {NCLAMP{1'b0}};
    end
    else
    begin
      sync_d_r      <= sync_in;
      fine_en_d_r   <= fine_en;
      coarse_en_d_r <= coarse_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clamp counters: load on trigger, count down, output while nonzero.
  // A retrigger reloads, so a sync edge mid-pulse restarts the on-time.
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (i = 0; i < NCLAMP; i = i + 1)
      begin
        fine_cnt_r[i]   <= `CTAR_RST_CNT;
        coarse_cnt_r[i] <= `CTAR_RST_CNT;
      end
      fine_on   <= {NCLAMP{1'b0}};
      coarse_on <= {NCLAMP{1'b0}};
      fine_up   <= {NCLAMP{1'b0}};
      coarse_up <= {NCLAMP{1'b0}};
    end
    else
    begin
      for (i = 0; i < NCLAMP; i = i + 1)
      begin
        if (fine_trig[i])
        begin
          fine_cnt_r[i] <= fine_time;                                  // [R20]
          fine_on[i]    <= (fine_time != `CTAR_RST_CNT);
        end
        else if (fine_cnt_r[i] != `CTAR_RST_CNT)
        begin
          fine_cnt_r[i] <= fine_cnt_r[i] - 3'h1;
          fine_on[i]    <= (fine_cnt_r[i] != 3'h1);
        end
        else
          fine_on[i] <= 1'b0;
        if (coarse_trig[i])
        begin
          coarse_cnt_r[i] <= coarse_time;                              // [R01] [R03] [R20]
          coarse_on[i]    <= (coarse_time != `CTAR_RST_CNT);
        end
        else if (coarse_cnt_r[i] != `CTAR_RST_CNT)
        begin
          coarse_cnt_r[i] <= coarse_cnt_r[i] - 3'h1;
          coarse_on[i]    <= (coarse_cnt_r[i] != 3'h1);
        end
        else
          coarse_on[i] <= 1'b0;
        // Direction only drives while the clamp is enabled
        fine_up[i]   <= fine_dir[i] & fine_en[i];
        coarse_up[i] <= coarse_dir[i] & coarse_en[i];                  // [R02]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog control outputs, registered from the fields
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_enable        <= 1'b1;
      bias_double       <= 1'b0;
      duty_equalizer_on <= 1'b0;
      core_clock_delay  <= 2'h0;
      ref_trim          <= 3'h0;
    end
    else
    begin
      osc_enable        <= timing_control_r[`CTAR_OSC_EN_BIT];           // [R05]
      bias_double       <= timing_control_r[`CTAR_BIAS_DBL_BIT];         // [R06]
      duty_equalizer_on <= timing_control_r[`CTAR_DCE_BIT];              // [R07]
      core_clock_delay  <= timing_control_r[`CTAR_CDLY_LSB +: 2];        // [R08]
      ref_trim          <= reference_adjust_r[`CTAR_REF_TRIM_LSB +: 3];  // [R11]
    end
  end

endmodule // ctar_regs
`default_nettype wire

// File: bench/ctar_regs_monitor.sv
// Checker of the clamp/timing/aux register bank ports
`timescale 1ns/1ps
`default_nettype none
module ctar_mon (
  // Clock, reset, register port
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [4:0] register_select,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  // Sync and clamp drive
  input wire logic       sync_in,
  input wire logic [2:0] coarse_on,
  input wire logic [2:0] coarse_up,
  // Analog controls
  input wire logic       osc_enable,
  input wire logic       bias_double,
  input wire logic       duty_equalizer_on,
  input wire logic [1:0] core_clock_delay,
  input wire logic [2:0] ref_trim
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic       vr_r;   // Next 0AH write goes to reference adjust
  logic [7:0] cr1_r;  // Shadow of clamp register 1
  logic [7:0] cr3_r;  // Shadow of coarse clamp control
  logic       pol_r;  // Shadow of sync polarity select
  logic [3:0] hi_cnt; // Cycles coarse clamp two has been on
  wire wa = reg_wr && register_select == 5'h0A;
  ////////////////////////////////////////////////////////////////////////
  // Shadows track host writes so expectations never come from the design
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      vr_r <= 1'b0;
      cr1_r <= 8'h00;
      cr3_r <= 8'h00;
      pol_r <= 1'b0;
      hi_cnt <= 4'h0;
    end
    else
    begin
      if (wa) vr_r <= ~vr_r;
      if (reg_wr && register_select == 5'h07) cr1_r <= reg_wdata;
      if (reg_wr && register_select == 5'h09) cr3_r <= reg_wdata;
      if (reg_wr && register_select == 5'h03) pol_r <= reg_wdata[5];
      hi_cnt <= coarse_on[1] ? hi_cnt + 4'h1 : 4'h0;
    end
  ////////////////////////////////////////////////////////////////////////
  AST_OSC: assert property (wa && !vr_r |-> ##2 osc_enable == $past(reg_wdata[0], 2))
    else $error("oscillator enable mismatch");
  AST_BIAS: assert property (wa && !vr_r |-> ##2 bias_double == $past(reg_wdata[1], 2))
    else $error("bias double mismatch");
  AST_DCE: assert property (wa && !vr_r |->
    ##2 duty_equalizer_on == $past(reg_wdata[3], 2)) else $error("duty equalizer mismatch");
  AST_CDLY: assert property (wa && !vr_r |->
    ##2 core_clock_delay == $past(reg_wdata[6:5], 2)) else $error("core clock delay mismatch");
  AST_TRIM: assert property (wa && vr_r |-> ##2 ref_trim == $past(reg_wdata[6:4], 2))
    else $error("reference trim mismatch");
  AST_UP: assert property (coarse_up == $past({cr3_r[4] & cr3_r[5], cr3_r[2] & cr3_r[3],
    cr3_r[0] & cr3_r[1]})) else $error("coarse direction not gated by enable");
  AST_TRIG: assert property ($rose(coarse_on[1]) |-> $past(cr3_r[3])
    && (cr1_r[6] || !$past(cr3_r[3], 3))) else $error("coarse clamp two fired without trigger");
  AST_SYNC: assert property (cr1_r[6] && cr3_r[3] && cr1_r[5:3] != 3'h0
    && sync_in != $past(sync_in) && sync_in == pol_r |-> ##1 coarse_on[1])
    else $error("sync edge did not fire clamp");
  AST_LEN: assert property ($fell(coarse_on[1]) |-> hi_cnt == {1'b0, cr1_r[5:3]})
    else $error("coarse clamp on-time wrong");
endmodule // ctar_mon
bind ctar_regs ctar_mon u_mon (.*);
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench of the clamp/timing/aux register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk, rst_n, reg_wr, sync_in, aux_selected;
  logic [4:0] register_select;
  logic [7:0] reg_wdata, reg_rdata;
  logic [63:0] aux_data;
  logic [2:0] fine_on, fine_up, coarse_on, coarse_up, ref_trim;
  logic osc_enable, bias_double, duty_equalizer_on;
  logic [1:0] core_clock_delay;
  int bad_count = 0;
  int n_checks = 0;
  ctar_regs uut (.*);
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One write strobe, released at the next falling edge
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge mclk);
    register_select = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask
  // Read data is registered, so wait past the select change
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(negedge mclk);
    register_select = a;
    repeat (2) @(negedge mclk);
    chk(reg_rdata, e);
  endtask
  // Count on-cycles of coarse two, coarse three and fine one
  task automatic win(input logic [7:0] e1, input logic [7:0] e2, input logic [7:0] e3);
    logic [7:0] c1, c2, c3;
    c1 = 0;
    c2 = 0;
    c3 = 0;
    repeat (12)
    begin
      @(negedge mclk);
      c1 += coarse_on[1];
      c2 += coarse_on[2];
      c3 += fine_on[0];
    end
    chk(c1, e1);
    chk(c2, e2);
    chk(c3, e3);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_timing;
    rd(5'h0A, 8'h01);
    rd(5'h1F, 8'h00);
    wr(5'h0A, 8'h6B);
    wr(5'h0A, 8'h51);
    repeat (2) @(negedge mclk);
    chk({osc_enable, bias_double, duty_equalizer_on, core_clock_delay}, 8'h1F);
    chk(ref_trim, 3'h5);
    wr(5'h0A, 8'h00);
    repeat (2) @(negedge mclk);
    chk(osc_enable, 1'b0);
    $display("timing test done");
  endtask
  task automatic t_unsync;
    wr(5'h07, 8'h18);
    wr(5'h09, 8'h38);
    win(3, 3, 0);
    chk(coarse_up, 3'h4);
    wr(5'h09, 8'h38);
    win(0, 0, 0);
    wr(5'h09, 8'h00);
    // Direction of clamp three set while it is disabled must not drive
    wr(5'h09, 8'h18);
    win(3, 0, 0);
    chk(coarse_up, 3'h0);
    $display("unsync test done");
  endtask
  task automatic t_sync;
    wr(5'h03, 8'h20);
    wr(5'h07, 8'h5A);
    wr(5'h08, 8'h03);
    wr(5'h09, 8'h28);
    win(0, 0, 0);
    sync_in = 1'b1;
    win(3, 3, 2);
    chk(fine_up, 3'h1);
    sync_in = 1'b0;
    win(0, 0, 0);
    wr(5'h03, 8'h00);
    sync_in = 1'b1;
    win(0, 0, 0);
    sync_in = 1'b0;
    win(3, 3, 2);
    $display("sync test done");
  endtask
  task automatic t_aux;
    for (int n = 0; n < 8; n++) aux_data[8*n +: 8] = 8'hA0 + n[7:0];
    aux_selected = 1'b1;
    repeat (4) @(negedge mclk);
    wr(5'h10, 8'hFF);
    for (int n = 0; n < 8; n++) rd(5'h10 + n[4:0], 8'hA0 + n[7:0]);
    // Results hold their last value once the aux configuration is left
    aux_selected = 1'b0;
    aux_data = 64'h0;
    repeat (2) @(negedge mclk);
    rd(5'h13, 8'hA3);
    $display("aux test done");
  endtask
  initial
  begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    register_select = 5'h00;
    reg_wdata = 8'h00;
    sync_in = 1'b0;
    aux_data = 64'h0;
    aux_selected = 1'b0;
    repeat (2) @(negedge mclk);
    chk(osc_enable, 1'b1);
    rst_n = 1'b1;
    t_timing();
    t_unsync();
    t_sync();
    t_aux();
    summarize();
  end
  initial
  begin
    #200000;
    bad_count++;
    summarize();
  end
endmodule // tb_top
`default_nettype wire
